// >>> hw/regfile_pkg.sv
package regfile_pkg;

  // Datapath shape of the core.
  localparam int DATA_W = 32;
  localparam int NUM_GPR = 16;
  localparam int IDX_W = 4;
  localparam int BUS_ADDR_W = 8;

  // Register offsets on the register port, byte addresses, one word each.
  localparam logic [7:0] OFS_GPR_BASE = 8'h00;
  localparam logic [7:0] OFS_GPR_LAST = 8'h3c;
  localparam logic [7:0] OFS_IRQ_STACK = 8'h40;
  localparam logic [7:0] OFS_USER_STACK = 8'h44;
  localparam logic [7:0] OFS_EXC_TABLE = 8'h48;
  localparam logic [7:0] OFS_IRQ_TABLE = 8'h4c;
  localparam logic [7:0] OFS_PC = 8'h50;
  localparam logic [7:0] OFS_PSW = 8'h54;
  localparam logic [7:0] OFS_BACKUP_PC = 8'h58;
  localparam logic [7:0] OFS_SAVED_PSW = 8'h5c;
  localparam logic [7:0] OFS_FAST_VECTOR = 8'h60;

  // Status word fields.
  localparam int PSW_U_BIT = 17;
  localparam int PSW_FLAG_LSB = 0;
  localparam int PSW_FLAG_W = 4;

  // Vector entries are one word, so the number is scaled by four.
  localparam int VEC_SHIFT = 2;
  localparam int VEC_NUM_W = 8;

  // Reset values.
  localparam logic [31:0] RST_GPR = 32'h0000_0000;
  localparam logic [31:0] RST_STACK = 32'h0000_0000;
  localparam logic [31:0] RST_TABLE = 32'h0000_0000;
  localparam logic [31:0] RST_PC = 32'h0000_0000;
  localparam logic [31:0] RST_PSW = 32'h0000_0000;
  localparam logic [31:0] RST_FAST_VECTOR = 32'h0000_0000;

  typedef enum logic {
    VEC_EXCEPTION,
    VEC_INTERRUPT
  } vec_kind_e;

endpackage : regfile_pkg

// >>> hw/gpr_bank_if.sv
`timescale 1ns/10ps
interface gpr_bank_if;
  logic we;
  logic [regfile_pkg::IDX_W-1:0] widx;
  logic [regfile_pkg::DATA_W-1:0] wdata;
  logic [regfile_pkg::IDX_W-1:0] ra_idx;
  logic [regfile_pkg::IDX_W-1:0] rb_idx;
  logic [regfile_pkg::IDX_W-1:0] rc_idx;
  logic [regfile_pkg::DATA_W-1:0] ra_data;
  logic [regfile_pkg::DATA_W-1:0] rb_data;
  logic [regfile_pkg::DATA_W-1:0] rc_data;

  modport bank (
    input we,
    input widx,
    input wdata,
    input ra_idx,
    input rb_idx,
    input rc_idx,
    output ra_data,
    output rb_data,
    output rc_data
  );

  modport user (
    output we,
    output widx,
    output wdata,
    output ra_idx,
    output rb_idx,
    output rc_idx,
    input ra_data,
    input rb_data,
    input rc_data
  );
endinterface : gpr_bank_if

// >>> hw/gpr_bank.sv
`timescale 1ns/10ps
// Holds general-purpose registers one and up; entry zero is the stack pointer pair kept by the parent.
module gpr_bank #(
  parameter int NUM_GPR = regfile_pkg::NUM_GPR
) (
  input wire logic sys_clk,
  input wire logic rst,
  gpr_bank_if.bank port
);

  logic [regfile_pkg::DATA_W-1:0] mem [1:NUM_GPR-1];

  generate
    if (NUM_GPR != (1 << regfile_pkg::IDX_W)) begin : g_bad_size
      $error("gpr_bank: NUM_GPR must equal two to the power of IDX_W");
    end
  endgenerate

  genvar i;
  generate
    for (i = 1; i < NUM_GPR; i++) begin : g_entry
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          mem[i] <= regfile_pkg::RST_GPR;
        end else if (port.we && (port.widx == regfile_pkg::IDX_W'(i))) begin
          mem[i] <= port.wdata;
        end
      end
    end
  endgenerate

  function automatic logic [regfile_pkg::DATA_W-1:0] read_entry(input logic [regfile_pkg::IDX_W-1:0] idx);
    read_entry = (idx == '0) ? regfile_pkg::RST_GPR : mem[idx];
  endfunction : read_entry

  assign port.ra_data = read_entry(port.ra_idx);
  assign port.rb_data = read_entry(port.rb_idx);
  assign port.rc_data = read_entry(port.rc_idx);

endmodule : gpr_bank

// >>> hw/cpu_register_file_fast_irq.sv
// Notes on behaviour
// - There are sixteen 32-bit general-purpose registers, each usable as data or as an address.
// - General-purpose register zero is also the stack pointer, so stack use sees its current value.
// - The stack pointer is the interrupt or the user stack pointer, picked by the stack select bit of the status word.
// - The exception table base holds the exception vector table start, and exception vector fetches are relative to it.
// - The interrupt table base holds the interrupt vector table start, and interrupt vector fetches are relative to it.
// - The program counter always holds the address of the instruction being executed.
// - The status word carries both instruction outcome flags and processor operating state.
// - Taking a fast interrupt copies the program counter into the backup program counter.
// - Taking a fast interrupt copies the status word into the saved status word, with the same bit layout.
// - A fast interrupt branches to the fast interrupt vector instead of fetching a vector from memory.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module cpu_register_file_fast_irq #(
  parameter int NUM_GPR = regfile_pkg::NUM_GPR
) (
  input wire logic sys_clk,
  input wire logic rst,
  // Core operand ports, answered one cycle later.
  input wire logic [regfile_pkg::IDX_W-1:0] rd_a_idx,
  input wire logic [regfile_pkg::IDX_W-1:0] rd_b_idx,
  output logic [regfile_pkg::DATA_W-1:0] rd_a_data,
  output logic [regfile_pkg::DATA_W-1:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [regfile_pkg::IDX_W-1:0] wr_idx,
  input wire logic [regfile_pkg::DATA_W-1:0] wr_data,
  // Program counter and status word updates from the core.
  input wire logic pc_load,
  input wire logic [regfile_pkg::DATA_W-1:0] pc_value,
  input wire logic psw_load,
  input wire logic [regfile_pkg::DATA_W-1:0] psw_value,
  input wire logic flag_we,
  input wire logic [regfile_pkg::PSW_FLAG_W-1:0] flag_value,
  // Fast interrupt entry and return.
  input wire logic fast_irq_take,
  input wire logic fast_irq_return,
  // Vector address lookup.
  input wire logic vec_req,
  input wire logic vec_kind,
  input wire logic [regfile_pkg::VEC_NUM_W-1:0] vec_num,
  output logic vec_valid,
  output logic [regfile_pkg::DATA_W-1:0] vec_addr,
  // State seen by the core.
  output logic [regfile_pkg::DATA_W-1:0] program_counter,
  output logic [regfile_pkg::DATA_W-1:0] processor_status_word,
  output logic [regfile_pkg::DATA_W-1:0] stack_pointer,
  // Register port.
  input wire logic [regfile_pkg::BUS_ADDR_W-1:0] bus_addr,
  input wire logic [regfile_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [regfile_pkg::DATA_W-1:0] bus_rdata
);

  generate
    if (NUM_GPR != (1 << regfile_pkg::IDX_W)) begin : g_bad_size
      $error("cpu_register_file_fast_irq: NUM_GPR must equal two to the power of IDX_W");
    end
  endgenerate

  generate
    if (regfile_pkg::PSW_U_BIT >= regfile_pkg::DATA_W) begin : g_bad_select_bit
      $error("cpu_register_file_fast_irq: the stack select bit lies outside the status word");
    end
  endgenerate

  generate
    if (int'(regfile_pkg::OFS_GPR_LAST) != (NUM_GPR - 1) * 4) begin : g_bad_gpr_map
      $error("cpu_register_file_fast_irq: the general register window does not match NUM_GPR");
    end
  endgenerate

  logic [regfile_pkg::DATA_W-1:0] interrupt_stack_pointer;
  logic [regfile_pkg::DATA_W-1:0] user_stack_pointer;
  logic [regfile_pkg::DATA_W-1:0] exception_table_base;
  logic [regfile_pkg::DATA_W-1:0] interrupt_table_base;
  logic [regfile_pkg::DATA_W-1:0] backup_program_counter;
  logic [regfile_pkg::DATA_W-1:0] saved_status_word;
  logic [regfile_pkg::DATA_W-1:0] fast_interrupt_vector;

  logic user_sel;
  logic [regfile_pkg::DATA_W-1:0] sp_now;
  logic bus_gpr_hit;
  logic [regfile_pkg::IDX_W-1:0] bus_gpr_idx;
  logic gpr_we;
  logic [regfile_pkg::IDX_W-1:0] gpr_widx;
  logic [regfile_pkg::DATA_W-1:0] gpr_wdata;
  logic gpr_zero_we;
  logic next_user_sel;
  logic [regfile_pkg::DATA_W-1:0] next_irq_stack;
  logic [regfile_pkg::DATA_W-1:0] next_user_stack;
  logic [regfile_pkg::DATA_W-1:0] next_pc;
  logic [regfile_pkg::DATA_W-1:0] next_psw;
  logic bus_set_irq_stack;
  logic bus_set_user_stack;
  logic bus_set_exc_table;
  logic bus_set_irq_table;
  logic bus_set_pc;
  logic bus_set_psw;
  logic bus_set_backup_pc;
  logic bus_set_saved_psw;
  logic bus_set_fast_vector;

  gpr_bank_if bank_port ();

  gpr_bank #(
    .NUM_GPR(NUM_GPR)
  ) u_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .port(bank_port)
  );

  function automatic logic bus_hit(input logic [regfile_pkg::BUS_ADDR_W-1:0] addr,
                                   input logic [regfile_pkg::BUS_ADDR_W-1:0] ofs);
    bus_hit = (addr == ofs);
  endfunction : bus_hit

  // Write strobes of the control registers on the register port, at most one high at a time.
  assign bus_set_irq_stack = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_IRQ_STACK);
  assign bus_set_user_stack = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_USER_STACK);
  assign bus_set_exc_table = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_EXC_TABLE);
  assign bus_set_irq_table = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_IRQ_TABLE);
  assign bus_set_pc = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_PC);
  assign bus_set_psw = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_PSW);
  assign bus_set_backup_pc = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_BACKUP_PC);
  assign bus_set_saved_psw = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_SAVED_PSW);
  assign bus_set_fast_vector = bus_we && bus_hit(bus_addr, regfile_pkg::OFS_FAST_VECTOR);

  assign user_sel = processor_status_word[regfile_pkg::PSW_U_BIT];
  assign sp_now = user_sel ? user_stack_pointer : interrupt_stack_pointer;

  // Register zero on the port is the selected stack pointer; the bank never holds a copy of it.
  assign bus_gpr_hit = (bus_addr <= regfile_pkg::OFS_GPR_LAST) && (bus_addr[1:0] == 2'b00);
  assign bus_gpr_idx = bus_addr[regfile_pkg::IDX_W+1:2];

  // The core write port wins over a register port write in the same cycle.
  always_comb begin
    gpr_we = 1'b0;
    gpr_widx = '0;
    gpr_wdata = wr_data;
    if (wr_en) begin
      gpr_we = 1'b1;
      gpr_widx = wr_idx;
    end else if (bus_we && bus_gpr_hit) begin
      gpr_we = 1'b1;
      gpr_widx = bus_gpr_idx;
      gpr_wdata = bus_wdata;
    end
  end

  assign gpr_zero_we = gpr_we && (gpr_widx == '0);

  assign bank_port.we = gpr_we && (gpr_widx != '0);
  assign bank_port.widx = gpr_widx;
  assign bank_port.wdata = gpr_wdata;
  assign bank_port.ra_idx = rd_a_idx;
  assign bank_port.rb_idx = rd_b_idx;
  assign bank_port.rc_idx = bus_gpr_idx;

  // Register zero writes land in the pointer chosen by the current select bit.
  always_comb begin
    next_irq_stack = interrupt_stack_pointer;
    next_user_stack = user_stack_pointer;
    if (gpr_zero_we) begin
      if (user_sel) begin
        next_user_stack = gpr_wdata;
      end else begin
        next_irq_stack = gpr_wdata;
      end
    end else begin
      if (bus_set_irq_stack) begin
        next_irq_stack = bus_wdata;
      end
      if (bus_set_user_stack) begin
        next_user_stack = bus_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_stack_pointer <= regfile_pkg::RST_STACK;
      user_stack_pointer <= regfile_pkg::RST_STACK;
    end else begin
      interrupt_stack_pointer <= next_irq_stack;
      user_stack_pointer <= next_user_stack;
    end
  end

  // Fast entry beats return, return beats a core load, a core load beats the register port.
  always_comb begin
    next_pc = program_counter;
    if (fast_irq_take) begin
      next_pc = fast_interrupt_vector;
    end else if (fast_irq_return) begin
      next_pc = backup_program_counter;
    end else if (pc_load) begin
      next_pc = pc_value;
    end else if (bus_set_pc) begin
      next_pc = bus_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      program_counter <= regfile_pkg::RST_PC;
    end else begin
      program_counter <= next_pc;
    end
  end

  // A flag update only touches the flag field and keeps the operating state bits.
  always_comb begin
    next_psw = processor_status_word;
    if (fast_irq_return) begin
      next_psw = saved_status_word;
    end else if (psw_load) begin
      next_psw = psw_value;
    end else if (bus_set_psw) begin
      next_psw = bus_wdata;
    end
    if (flag_we && !fast_irq_return) begin
      next_psw[regfile_pkg::PSW_FLAG_LSB +: regfile_pkg::PSW_FLAG_W] = flag_value;
    end
  end

  assign next_user_sel = next_psw[regfile_pkg::PSW_U_BIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      processor_status_word <= regfile_pkg::RST_PSW;
    end else begin
      processor_status_word <= next_psw;
    end
  end

  // The visible stack pointer tracks what register zero will read next cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stack_pointer <= regfile_pkg::RST_STACK;
    end else begin
      stack_pointer <= next_user_sel ? next_user_stack : next_irq_stack;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      backup_program_counter <= regfile_pkg::RST_PC;
      saved_status_word <= regfile_pkg::RST_PSW;
    end else if (fast_irq_take) begin
      backup_program_counter <= program_counter;
      saved_status_word <= processor_status_word;
    end else begin
      if (bus_set_backup_pc) begin
        backup_program_counter <= bus_wdata;
      end
      if (bus_set_saved_psw) begin
        saved_status_word <= bus_wdata;
      end
    end
  end

  // Table bases are kept as written; keeping them word aligned is left to software.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exception_table_base <= regfile_pkg::RST_TABLE;
      interrupt_table_base <= regfile_pkg::RST_TABLE;
      fast_interrupt_vector <= regfile_pkg::RST_FAST_VECTOR;
    end else begin
      if (bus_set_exc_table) begin
        exception_table_base <= bus_wdata;
      end
      if (bus_set_irq_table) begin
        interrupt_table_base <= bus_wdata;
      end
      if (bus_set_fast_vector) begin
        fast_interrupt_vector <= bus_wdata;
      end
    end
  end

  // Vector fetch address, one word per vector number from the chosen table start.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_valid <= 1'b0;
      vec_addr <= regfile_pkg::RST_TABLE;
    end else begin
      vec_valid <= vec_req;
      if (vec_req) begin
        if (vec_kind == regfile_pkg::VEC_EXCEPTION) begin
          vec_addr <= exception_table_base
                      + (regfile_pkg::DATA_W'(vec_num) << regfile_pkg::VEC_SHIFT);
        end else begin
          vec_addr <= interrupt_table_base
                      + (regfile_pkg::DATA_W'(vec_num) << regfile_pkg::VEC_SHIFT);
        end
      end
    end
  end

  // Operand reads see the state before any write in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_a_data <= regfile_pkg::RST_GPR;
      rd_b_data <= regfile_pkg::RST_GPR;
    end else begin
      rd_a_data <= (rd_a_idx == '0) ? sp_now : bank_port.ra_data;
      rd_b_data <= (rd_b_idx == '0) ? sp_now : bank_port.rb_data;
    end
  end

  function automatic logic [regfile_pkg::DATA_W-1:0] bus_read(input logic [regfile_pkg::BUS_ADDR_W-1:0] addr);
    bus_read = '0;
    unique case (addr)
      regfile_pkg::OFS_IRQ_STACK: bus_read = interrupt_stack_pointer;
      regfile_pkg::OFS_USER_STACK: bus_read = user_stack_pointer;
      regfile_pkg::OFS_EXC_TABLE: bus_read = exception_table_base;
      regfile_pkg::OFS_IRQ_TABLE: bus_read = interrupt_table_base;
      regfile_pkg::OFS_PC: bus_read = program_counter;
      regfile_pkg::OFS_PSW: bus_read = processor_status_word;
      regfile_pkg::OFS_BACKUP_PC: bus_read = backup_program_counter;
      regfile_pkg::OFS_SAVED_PSW: bus_read = saved_status_word;
      regfile_pkg::OFS_FAST_VECTOR: bus_read = fast_interrupt_vector;
      default: bus_read = '0;
    endcase
  endfunction : bus_read

  // Unmapped addresses read as zero; the data stand for the one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_rdata <= '0;
    end else if (bus_re) begin
      if (bus_gpr_hit) begin
        bus_rdata <= (bus_gpr_idx == '0) ? sp_now : bank_port.rc_data;
      end else begin
        bus_rdata <= bus_read(bus_addr);
      end
    end else begin
      bus_rdata <= '0;
    end
  end

endmodule : cpu_register_file_fast_irq

// >>> verif/cpu_register_file_fast_irq_asserts.sv
`timescale 1ns/10ps
module cpu_register_file_fast_irq_asserts #(
  parameter int NUM_GPR = regfile_pkg::NUM_GPR
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] rd_a_idx,
  input wire logic [31:0] rd_a_data,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic psw_load,
  input wire logic [31:0] psw_value,
  input wire logic flag_we,
  input wire logic [3:0] flag_value,
  input wire logic fast_irq_take,
  input wire logic fast_irq_return,
  input wire logic vec_req,
  input wire logic vec_valid,
  input wire logic [31:0] program_counter,
  input wire logic [31:0] processor_status_word,
  input wire logic [31:0] stack_pointer,
  input wire logic bus_we
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  gpr_readback_a: assert property (
    wr_en && wr_idx != 0 && rd_a_idx == wr_idx ##1 rd_a_idx == $past(rd_a_idx)
    |=> rd_a_data == $past(wr_data, 2)) else $error("operand read back differs from written word");
  stack_view_a: assert property (
    rd_a_idx == 0 && !wr_en && !bus_we && !psw_load && !fast_irq_take && !fast_irq_return
    |=> rd_a_data == stack_pointer) else $error("register zero read differs from stack pointer");
  pc_load_a: assert property (
    pc_load && !fast_irq_take && !fast_irq_return |=> program_counter == $past(pc_value))
    else $error("program counter load lost");
  psw_load_a: assert property (
    psw_load && !flag_we && !fast_irq_return |=> processor_status_word == $past(psw_value))
    else $error("status word load lost");
  flag_update_a: assert property (
    flag_we && !psw_load && !fast_irq_return |=> processor_status_word[3:0] == $past(flag_value))
    else $error("status flags not updated");
  take_keeps_psw_a: assert property (
    fast_irq_take && !psw_load && !flag_we && !bus_we |=> $stable(processor_status_word))
    else $error("fast interrupt changed status word");
  fast_round_trip_a: assert property (
    fast_irq_take && !fast_irq_return ##1 fast_irq_return && !fast_irq_take && !bus_we
    |=> program_counter == $past(program_counter, 2) && processor_status_word == $past(processor_status_word, 2))
    else $error("fast interrupt return did not restore state");
  vec_pulse_a: assert property (vec_req |=> vec_valid) else $error("vector answer missing");
  vec_cause_a: assert property (vec_valid |-> $past(vec_req)) else $error("vector answer without request");

  cover property (fast_irq_take ##1 fast_irq_return);
  cover property (vec_req ##1 vec_req);
  cover property (psw_load ##1 rd_a_idx == 0);
endmodule : cpu_register_file_fast_irq_asserts

bind cpu_register_file_fast_irq cpu_register_file_fast_irq_asserts #(.NUM_GPR(NUM_GPR)) u_chk (.sys_clk, .rst,
  .rd_a_idx, .rd_a_data, .wr_en, .wr_idx, .wr_data, .pc_load, .pc_value, .psw_load, .psw_value, .flag_we,
  .flag_value, .fast_irq_take, .fast_irq_return, .vec_req, .vec_valid, .program_counter,
  .processor_status_word, .stack_pointer, .bus_we);

// >>> verif/cpu_register_file_fast_irq_test.sv
`timescale 1ns/10ps
module cpu_register_file_fast_irq_test;
  localparam int BW = 1, BR = 2, CW = 4, PL = 8, SL = 16, FL = 32, TK = 64, RT = 128, VQ = 256, OR = 512;
  logic sys_clk, rst, wr_en, pc_load, psw_load, flag_we, fast_irq_take, fast_irq_return;
  logic vec_req, vec_kind, vec_valid, bus_we, bus_re, op_rd, re_q, op_q, vq_q;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx, flag_value;
  logic [7:0] vec_num, bus_addr, n8;
  logic [31:0] wr_data, pc_value, psw_value, bus_wdata, rd_a_data, rd_b_data, vec_addr, bus_rdata;
  logic [31:0] program_counter, processor_status_word, stack_pointer, ev, x, y, z, p, s, f, eb, ib;
  logic [31:0] q_bus[$], q_vec[$], q_op[$];
  int seed = 73111;
  int error_cnt = 0, checks_done = 0, cycle_cnt = 0;

  cpu_register_file_fast_irq #(.NUM_GPR(16)) u_cpu_register_file_fast_irq (.sys_clk, .rst, .rd_a_idx,
    .rd_b_idx, .rd_a_data, .rd_b_data, .wr_en, .wr_idx, .wr_data, .pc_load, .pc_value, .psw_load,
    .psw_value, .flag_we, .flag_value, .fast_irq_take, .fast_irq_return, .vec_req, .vec_kind, .vec_num,
    .vec_valid, .vec_addr, .program_counter, .processor_status_word, .stack_pointer, .bus_addr,
    .bus_wdata, .bus_we, .bus_re, .bus_rdata);

  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checks_done++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, v);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // One cycle of stimulus; every input is set once, so calls may follow back to back.
  task automatic cyc(input int c, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge sys_clk);
    {op_rd, vec_req, fast_irq_return, fast_irq_take, flag_we, psw_load, pc_load, wr_en, bus_re, bus_we} <= c[9:0];
    bus_addr <= a;
    bus_wdata <= d;
    wr_idx <= a[5:2];
    wr_data <= d;
    pc_value <= d;
    psw_value <= d;
    flag_value <= d[3:0];
    vec_kind <= a[0];
    vec_num <= d[7:0];
    rd_a_idx <= a[5:2];
    rd_b_idx <= a[5:2];
    if (c[1]) q_bus.push_back(e);
    if (c[8]) q_vec.push_back(e);
    if (c[9]) q_op.push_back(e);
  endtask : cyc

  always @(posedge sys_clk) begin
    if (rst) begin
      re_q <= 0;
      op_q <= 0;
      vq_q <= 0;
    end else begin
      ev = re_q ? q_bus.pop_front() : '0;
      chk("bus_rdata", ev, bus_rdata);
      chk("vec_valid", {31'h0, vq_q}, {31'h0, vec_valid});
      if (vq_q) chk("vec_addr", q_vec.pop_front(), vec_addr);
      if (op_q) begin
        ev = q_op.pop_front();
        chk("rd_a_data", ev, rd_a_data);
        chk("rd_b_data", ev, rd_b_data);
      end
      re_q <= bus_re;
      op_q <= op_rd;
      vq_q <= vec_req;
    end
  end

  always @(posedge sys_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 2000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    {wr_en, pc_load, psw_load, flag_we, fast_irq_take, fast_irq_return, vec_req, vec_kind, bus_we, bus_re} = '0;
    {rd_a_idx, rd_b_idx, wr_idx, flag_value, vec_num, bus_addr, op_rd} = '0;
    {wr_data, pc_value, psw_value, bus_wdata} = '0;
    rst = 1;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    for (int i = 0; i < 26; i++) cyc(BR, 8'(i * 4), 0, 0);
    cyc(BW, 8'h41, 32'hffff_ffff, 0);
    cyc(BR, 8'h41, 0, 0);
    cyc(BR, 8'h40, 0, 0);
    $display("reset and unmapped done");
    for (int n = 1; n < 16; n++) begin
      x = $random(seed);
      cyc(CW, 8'(n * 4), x, 0);
      cyc(BR | OR, 8'(n * 4), 0, x);
    end
    cyc(BW, 8'h08, x, 0);
    cyc(BR | OR, 8'h08, 0, x);
    $display("general registers done");
    x = $random(seed) & 32'hffff_fffc;
    y = $random(seed) & 32'hffff_fffc;
    z = $random(seed);
    cyc(BW, 8'h40, x, 0);
    cyc(BW, 8'h44, y, 0);
    cyc(BR | OR, 8'h00, 0, x);
    cyc(SL, 8'h00, 32'h0002_0000, 0);
    cyc(BR | OR, 8'h00, 0, y);
    #1 chk("stack_pointer", y, stack_pointer);
    cyc(CW, 8'h00, z, 0);
    cyc(BR, 8'h44, 0, z);
    cyc(BR, 8'h40, 0, x);
    cyc(SL, 8'h00, 0, 0);
    cyc(BR | OR, 8'h00, 0, x);
    $display("stack pointers done");
    eb = $random(seed) & 32'hffff_fffc;
    ib = $random(seed) & 32'hffff_fffc;
    cyc(BW, 8'h48, eb, 0);
    cyc(BW, 8'h4c, ib, 0);
    for (int k = 0; k < 4; k++) begin
      n8 = k[0] ? 8'hff : 8'h00;
      cyc(VQ, {7'h00, k[1]}, {24'h00_0000, n8}, (k[1] ? ib : eb) + {22'h00_0000, n8, 2'b00});
    end
    $display("vector tables done");
    p = $random(seed);
    s = $random(seed);
    cyc(PL, 8'h00, p, 0);
    cyc(BR, 8'h50, 0, p);
    cyc(SL, 8'h00, s, 0);
    cyc(FL, 8'h00, 32'h0000_000a, 0);
    s = {s[31:4], 4'ha};
    cyc(BR, 8'h54, 0, s);
    #1 chk("processor_status_word", s, processor_status_word);
    $display("counter and status done");
    f = $random(seed);
    cyc(BW, 8'h60, f, 0);
    cyc(TK, 8'h00, 0, 0);
    cyc(RT | BR, 8'h58, 0, p);
    #1 chk("program_counter", f, program_counter);
    cyc(BR, 8'h5c, 0, s);
    cyc(BR, 8'h50, 0, p);
    cyc(BR, 8'h54, 0, s);
    cyc(BW, 8'h50, z, 0);
    cyc(BW, 8'h58, f, 0);
    cyc(BW, 8'h54, p, 0);
    cyc(BR, 8'h50, 0, z);
    cyc(BR, 8'h58, 0, f);
    cyc(BR, 8'h54, 0, p);
    cyc(0, 8'h00, 0, 0);
    repeat (3) @(posedge sys_clk);
    $display("fast interrupt done");
    test_done();
  end
endmodule : cpu_register_file_fast_irq_test
